// ==== nvsc_pkg.sv ====
// package for the nonvolatile sram soft sequence host controller
// assumes a 100 MHz mclk and an asynchronous sram bus on the far side
package nvsc_pkg;
   // ==========================================
   // sequence addresses
   localparam logic [15:0] NVSC_SEQ_A1 = 16'h4E38;
   localparam logic [15:0] NVSC_SEQ_A2 = 16'hB1C7;
   localparam logic [15:0] NVSC_SEQ_A3 = 16'h83E0;
   localparam logic [15:0] NVSC_SEQ_A4 = 16'h7C1F;
   localparam logic [15:0] NVSC_SEQ_A5 = 16'h703F;
   localparam logic [15:0] NVSC_ADDR_RECALL = 16'h4C63;
   localparam logic [15:0] NVSC_ADDR_AS_DIS = 16'h8B45;
   localparam logic [15:0] NVSC_ADDR_AS_EN = 16'h4B46;
   localparam logic [15:0] NVSC_ADDR_STORE = 16'h8FC0;
   localparam int NVSC_AW = 20;
   localparam int NVSC_DW = 16;
   // ==========================================
   // timing
   localparam int NVSC_CLK_MHZ = 100;
   localparam int NVSC_T_STROBE_NS = 45;
   localparam int NVSC_STROBE_CYC = (NVSC_T_STROBE_NS * NVSC_CLK_MHZ + 999) / 1000;
   localparam int NVSC_T_GAP_NS = 20;
   localparam int NVSC_GAP_CYC = (NVSC_T_GAP_NS * NVSC_CLK_MHZ + 999) / 1000;
   localparam int NVSC_CW = 4;
   // ==========================================
   // commands
   typedef enum logic [1:0] {
      NVSC_CMD_RECALL,
      NVSC_CMD_AS_DIS,
      NVSC_CMD_AS_EN,
      NVSC_CMD_STORE
   } nvsc_cmd_t;
   typedef struct packed {
      logic [NVSC_AW-1:0] addr;
      logic ce_n;
      logic oe_n;
      logic we_n;
      logic upper_byte_sel_n;
      logic lower_byte_sel_n;
   } nvsc_bus_t;
   localparam nvsc_bus_t NVSC_BUS_IDLE = '{addr: '0, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
      upper_byte_sel_n: 1'b1, lower_byte_sel_n: 1'b1};
endpackage

// ==== nvsc_host.sv ====
// host controller that issues six-read soft sequences to a nonvolatile sram
// assumes the memory bus is owned by this block while a command runs
`timescale 1ns/1ps
module nvsc_host
   import nvsc_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic cmd_valid,
   input wire nvsc_pkg::nvsc_cmd_t cmd,
   input wire logic boot_config,
   input wire logic hardware_store_busy_n,
   output nvsc_pkg::nvsc_bus_t bus,
   output logic cmd_ready,
   output logic cmd_done,
   output logic as_dirty
);
   import nvsc_pkg::*;
   // ==========================================
   // state
   typedef enum logic [2:0] {S_IDLE, S_ADDR, S_STROBE, S_GAP, S_BUSY} nvsc_state_t;
   nvsc_state_t st_r, st_nxt;
   nvsc_cmd_t cmd_r, cmd_nxt;
   // index of the read within the six-read sequence
   logic [2:0] step_r, step_nxt;
   // counts down strobe and gap cycles; the width fits the longest count
   logic [NVSC_CW-1:0] cnt_r, cnt_nxt;
   nvsc_bus_t bus_nxt;
   logic ready_nxt;
   logic done_nxt;
   logic dirty_r;
   logic dirty_nxt;
   // boot rewrite pending; loaded from boot_config while reset is held
   logic boot_r;
   logic boot_nxt;
   logic busy_s1_r, busy_s2_r;
   logic [15:0] seq_addr;

   // timing of one read, in mclk cycles:
   // one address cycle, NVSC_STROBE_CYC strobe cycles, NVSC_GAP_CYC gap cycles
   // six reads take about 48 cycles; a recall or store adds the busy time
   // a fixed strobe length keeps the host simple but wastes time on faster parts

   // ==========================================
   // busy synchroniser
   // the busy pin is driven by the memory, not by mclk logic, so two flops
   always_ff @(posedge mclk) begin
      busy_s1_r <= hardware_store_busy_n;
      busy_s2_r <= busy_s1_r;
   end

   // ==========================================
   // address lookup
   // sixth address selected by command
   // only bits 14 down to 2 are decoded by the memory; bits 19 down to 16 stay at zero
   always_comb begin
      unique case (step_r)
         3'd0: seq_addr = NVSC_SEQ_A1;
         3'd1: seq_addr = NVSC_SEQ_A2;
         3'd2: seq_addr = NVSC_SEQ_A3;
         3'd3: seq_addr = NVSC_SEQ_A4;
         3'd4: seq_addr = NVSC_SEQ_A5;
         default: begin
            unique case (cmd_r)
               NVSC_CMD_RECALL: seq_addr = NVSC_ADDR_RECALL;
               NVSC_CMD_AS_DIS: seq_addr = NVSC_ADDR_AS_DIS;
               NVSC_CMD_AS_EN: seq_addr = NVSC_ADDR_AS_EN;
               default: seq_addr = NVSC_ADDR_STORE;
            endcase
         end
      endcase
   end

   // ==========================================
   // sequencer
   // idle waits for a command or a pending boot rewrite, then six reads run
   // back to back; after the last one the host waits for busy to be released
   // the bus is never shared during a sequence, since any other access
   // would abort it in the memory
   always_comb begin
      st_nxt = st_r;
      cmd_nxt = cmd_r;
      step_nxt = step_r;
      cnt_nxt = cnt_r;
      bus_nxt = bus;
      ready_nxt = 1'b0;
      done_nxt = 1'b0;
      dirty_nxt = dirty_r;
      boot_nxt = boot_r;
      unique case (st_r)
         S_IDLE: begin
            bus_nxt = NVSC_BUS_IDLE;
            // boot rewrite of autostore enable takes priority once
            // boot_config is sampled only while rst is high; later changes do nothing
            // the rewrite leaves as_dirty set, so a store is still owed
            if (boot_r && busy_s2_r) begin
               boot_nxt = 1'b0;
               cmd_nxt = NVSC_CMD_AS_EN;
               step_nxt = 3'd0;
               st_nxt = S_ADDR;
            end else if (cmd_valid && busy_s2_r) begin
               cmd_nxt = cmd;
               step_nxt = 3'd0;
               st_nxt = S_ADDR;
            end else begin
               ready_nxt = busy_s2_r && !boot_r;
            end
         end
         S_ADDR: begin
            // address settles before the chip-select strobe; no other access is
            // interleaved since the bus is ours until the sequence ends
            bus_nxt = NVSC_BUS_IDLE;
            bus_nxt.addr = {4'h0, seq_addr};
            cnt_nxt = NVSC_CW'(NVSC_STROBE_CYC);
            st_nxt = S_STROBE;
         end
         S_STROBE: begin
            // byte selects low so the read is a full word read
            bus_nxt.ce_n = 1'b0;
            bus_nxt.oe_n = 1'b0;
            bus_nxt.we_n = 1'b1;
            bus_nxt.upper_byte_sel_n = 1'b0;
            bus_nxt.lower_byte_sel_n = 1'b0;
            cnt_nxt = cnt_r - NVSC_CW'(1);
            if (cnt_r == NVSC_CW'(1)) begin
               cnt_nxt = NVSC_CW'(NVSC_GAP_CYC);
               st_nxt = S_GAP;
            end
         end
         S_GAP: begin
            // strobes high between reads so each read has its own falling edge
            bus_nxt.ce_n = 1'b1;
            bus_nxt.oe_n = 1'b1;
            cnt_nxt = cnt_r - NVSC_CW'(1);
            if (cnt_r == NVSC_CW'(1)) begin
               if (step_r == 3'd5) begin
                  st_nxt = S_BUSY;
               end else begin
                  step_nxt = step_r + 3'd1;
                  st_nxt = S_ADDR;
               end
            end
         end
         S_BUSY: begin
            // wait for the device to release busy after recall or store
            // enable and disable never raise busy; they finish on the
            // first cycle in S_BUSY
            bus_nxt = NVSC_BUS_IDLE;
            if (busy_s2_r) begin
               done_nxt = 1'b1;
               st_nxt = S_IDLE;
               if (cmd_r == NVSC_CMD_AS_DIS || cmd_r == NVSC_CMD_AS_EN) begin
                  dirty_nxt = 1'b1;
               end else if (cmd_r == NVSC_CMD_STORE) begin
                  dirty_nxt = 1'b0;
               end
            end
         end
         default: st_nxt = S_IDLE;
      endcase
   end

   // ==========================================
   // registers
   // one process holds every flop except the busy synchroniser, so that reset covers them
   always_ff @(posedge mclk) begin
      if (rst) begin
         st_r <= S_IDLE;
         cmd_r <= NVSC_CMD_RECALL;
         step_r <= 3'd0;
         cnt_r <= '0;
         bus <= NVSC_BUS_IDLE;
         cmd_ready <= 1'b0;
         cmd_done <= 1'b0;
         dirty_r <= 1'b0;
         boot_r <= boot_config;
      end else begin
         st_r <= st_nxt;
         cmd_r <= cmd_nxt;
         step_r <= step_nxt;
         cnt_r <= cnt_nxt;
         bus <= bus_nxt;
         cmd_ready <= ready_nxt;
         cmd_done <= done_nxt;
         dirty_r <= dirty_nxt;
         boot_r <= boot_nxt;
      end
   end


   // ==========================================
   // outputs
   // as_dirty is a plain copy of a flop, so it carries no glitch
   always_comb begin
      as_dirty = dirty_r;
   end
endmodule // nvsc_host

// ==== nvsc_checker.sv ====
// checker: host side bus rules
// sees only the ports of nvsc_host
`timescale 1ns/1ps
module nvsc_checker
   import nvsc_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic cmd_valid,
   input wire nvsc_pkg::nvsc_cmd_t cmd,
   input wire logic boot_config,
   input wire logic hardware_store_busy_n,
   input wire nvsc_pkg::nvsc_bus_t bus,
   input wire logic cmd_ready,
   input wire logic cmd_done,
   input wire logic as_dirty
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   // ==========================================
   // assertions
   a_we_high: assert property (bus.we_n) else $error("we_n low");
   a_ce_oe_pair: assert property (bus.ce_n == bus.oe_n) else $error("ce oe split");
   a_strobe_len: assert property ($fell(bus.ce_n) |-> !bus.ce_n[*5] ##1 bus.ce_n)
      else $error("strobe length");
   a_addr_held: assert property (!bus.ce_n |-> $stable(bus.addr)) else $error("addr moved");
   a_upper_zero: assert property (bus.addr[19:16] == 4'h0) else $error("upper addr");
   a_first_read: assert property (cmd_ready && cmd_valid
      |-> ##[1:2] bus.addr[15:0] == NVSC_SEQ_A1) else $error("first addr");
   a_take_drops: assert property (cmd_ready && cmd_valid |=> !cmd_ready) else $error("ready");
   a_done_pulse: assert property (cmd_done |=> !cmd_done) else $error("done width");
   a_busy_quiet: assert property (!hardware_store_busy_n[*3] |-> !$fell(bus.ce_n))
      else $error("strobe while busy");
   c_done: cover property (cmd_done);
   c_busy: cover property ($fell(hardware_store_busy_n));
   c_dirty: cover property ($rose(as_dirty));
endmodule // nvsc_checker
bind nvsc_host nvsc_checker u_chk (.mclk, .rst, .cmd_valid, .cmd, .boot_config,
   .hardware_store_busy_n, .bus, .cmd_ready, .cmd_done, .as_dirty);

// ==== nvsc_dev.sv ====
// device model: decodes six-read soft sequences
// assumes the host bus is the only master
`timescale 1ns/1ps
module nvsc_dev
   import nvsc_pkg::*;
#(parameter int BUSY_CYC = 20)
(
   input wire logic mclk,
   input wire nvsc_pkg::nvsc_bus_t bus,
   output logic busy_n,
   output logic as_en = 1'b1,
   output nvsc_pkg::nvsc_cmd_t op = NVSC_CMD_STORE
);
   logic [15:0] sq [5] = '{NVSC_SEQ_A1, NVSC_SEQ_A2, NVSC_SEQ_A3, NVSC_SEQ_A4, NVSC_SEQ_A5};
   logic [12:0] a;
   logic ce_q = 1'b1;
   int step = 0;
   int cnt = 0;
   // nonvolatile word ships as zero and is only read by a recall
   logic [7:0] nv_q = 8'h00;
   logic [7:0] sram_q = 8'h00;
   // data drivers float on the sixth read of every sequence
   logic dq_oe = 1'b0;
   logic wr_block = 1'b1;
   assign a = bus.addr[14:2];
   assign busy_n = (cnt == 0);
   always @(posedge mclk) begin
      ce_q <= bus.ce_n;
      if (cnt > 0) cnt <= cnt - 1;
      wr_block <= (cnt > 0);
      if (cnt == 1 && op == NVSC_CMD_RECALL) sram_q <= nv_q;
      // accesses while busy are ignored, not queued
      if (cnt == 0 && ce_q && !bus.ce_n) begin
         if (!bus.we_n) step <= 0;
         else if (step < 5) begin
            step <= (a == sq[step][14:2]) ? step + 1 : 0;
            dq_oe <= 1'b1;
         end else begin
            step <= 0;
            dq_oe <= 1'b0;
            if (a == NVSC_ADDR_RECALL[14:2]) sram_q <= 8'h00;
            case (a)
               NVSC_ADDR_RECALL[14:2]: op <= NVSC_CMD_RECALL;
               NVSC_ADDR_AS_DIS[14:2]: op <= NVSC_CMD_AS_DIS;
               NVSC_ADDR_AS_EN[14:2]: op <= NVSC_CMD_AS_EN;
               default: op <= NVSC_CMD_STORE;
            endcase
            if (a == NVSC_ADDR_AS_DIS[14:2]) as_en <= 1'b0;
            if (a == NVSC_ADDR_AS_EN[14:2]) as_en <= 1'b1;
            if (a == NVSC_ADDR_RECALL[14:2] || a == NVSC_ADDR_STORE[14:2]) cnt <= BUSY_CYC;
         end
      end
   end
endmodule // nvsc_dev

// ==== nvsc_host_test.sv ====
// bench: nvsc_host driving the device model
`timescale 1ns/1ps
module nvsc_host_test;
   import nvsc_pkg::*;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic cmd_valid = 1'b0;
   logic boot_cfg = 1'b0;
   nvsc_cmd_t cmd = NVSC_CMD_RECALL;
   logic busy_n, as_en, cmd_ready, cmd_done, as_dirty;
   nvsc_cmd_t op;
   nvsc_bus_t bus;
   int err_total = 0;
   int n_compared = 0;
   nvsc_host DUT (.mclk, .rst, .cmd_valid, .cmd, .boot_config(boot_cfg),
      .hardware_store_busy_n(busy_n), .bus, .cmd_ready, .cmd_done, .as_dirty);
   nvsc_dev #(.BUSY_CYC(30)) u_dev (.mclk, .bus, .busy_n, .as_en, .op);
   initial forever #5 mclk = ~mclk;
   task automatic chk(string nm, logic [19:0] got, logic [19:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic print_verdict;
      $display("compared %0d errors %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // one full command; the last strobed address and whether busy went low are checked
   task automatic run(nvsc_cmd_t c, logic [15:0] a6, logic en, logic dty);
      int n;
      int lo;
      logic [19:0] last;
      lo = 0;
      for (n = 0; n < 50 && cmd_ready !== 1'b1; n++) @(posedge mclk) #1;
      chk("ready", cmd_ready, 1);
      if (n >= 50) print_verdict();
      cmd = c;
      cmd_valid = 1'b1;
      @(posedge mclk) #1;
      cmd_valid = 1'b0;
      for (n = 0; n < 600 && cmd_done !== 1'b1; n++) begin
         @(posedge mclk) #1;
         lo += !busy_n;
         if (!bus.ce_n) last = bus.addr;
      end
      chk("done", n < 600, 1);
      if (n >= 600) print_verdict();
      chk("sixth", last, {4'h0, a6});
      chk("op", op, c);
      chk("busy", lo > 0, c == NVSC_CMD_RECALL || c == NVSC_CMD_STORE);
      chk("aflag", as_en, en);
      @(posedge mclk) #1;
      chk("dirty", as_dirty, dty);
   endtask
   // boot rewrite: the host re-enables autostore by itself after reset
   task automatic boot_check;
      int n;
      for (n = 0; n < 200 && cmd_ready !== 1'b1; n++) @(posedge mclk) #1;
      chk("boot", n < 200, 1);
      if (n >= 200) print_verdict();
      chk("bootflag", as_en, 1);
      chk("bootdirty", as_dirty, 1);
   endtask
   task automatic reset_check;
      rst = 1'b1;
      repeat (3) @(posedge mclk) #1;
      chk("ce_n", bus.ce_n, 1);
      chk("ready", cmd_ready, 0);
      chk("dirty", as_dirty, 0);
      rst = 1'b0;
   endtask
   initial begin
      reset_check();
      chk("ship", as_en, 1);
      run(NVSC_CMD_RECALL, NVSC_ADDR_RECALL, 1, 0);
      run(NVSC_CMD_AS_DIS, NVSC_ADDR_AS_DIS, 0, 1);
      run(NVSC_CMD_STORE, NVSC_ADDR_STORE, 0, 0);
      run(NVSC_CMD_AS_EN, NVSC_ADDR_AS_EN, 1, 1);
      run(NVSC_CMD_RECALL, NVSC_ADDR_RECALL, 1, 1);
      run(NVSC_CMD_AS_DIS, NVSC_ADDR_AS_DIS, 0, 1);
      boot_cfg = 1'b1;
      reset_check();
      boot_check();
      print_verdict();
   end
endmodule // nvsc_host_test
